// File: rtl/eepc_regs.svh
`ifndef EEPC_REGS_SVH
`define EEPC_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses on the control port.
// ----------------------------------------------------------------------------
`define EEPC_ADDR_CTRL 12'hFF0
`define EEPC_ADDR_MCR 12'hFF1
`define EEPC_ADDR_DIVH 12'hFF2
`define EEPC_ADDR_DIVL 12'hFF3
`define EEPC_ADDR_PROT 12'hFF4
`define EEPC_REG_BASE 12'hFF0
`define EEPC_SHADOW_HI 12'hFC0
`define EEPC_SHADOW_LO 12'hFC1

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define EEPC_B_GUARD 7
`define EEPC_B_AUTO 5
`define EEPC_B_BYTE 4
`define EEPC_B_ROW 3
`define EEPC_B_ERASE 2
`define EEPC_B_LATCH 1
`define EEPC_B_VAPPLY 0
`define EEPC_B_DBGLOCK 7
`define EEPC_B_HIDE 6
`define EEPC_B_SGUARD 7

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define EEPC_MCR_LOW_RESET 4'h0
`define EEPC_PROT_RESET 1'b1
`define EEPC_GUARD_RESET 1'b1

// ----------------------------------------------------------------------------
// Timing: the automatic interval is counted in divider ticks.
// ----------------------------------------------------------------------------
`define EEPC_CLK_MHZ 50
`define EEPC_PROG_TIME_MS 10
`define EEPC_TICK_US 1
`define EEPC_PROG_TICKS (`EEPC_PROG_TIME_MS * 1000 / `EEPC_TICK_US)

`endif

// File: rtl/eepc_pkg.sv
package eepc_pkg;

	// Erase granularity, one-hot.
	typedef enum logic [2:0] {
		SCOPE_BYTE = 3'b001,
		SCOPE_ROW = 3'b010,
		SCOPE_BULK = 3'b100
	} eepc_scope_t;

	// Interval timer states, one-hot.
	typedef enum logic [2:0] {
		TMR_IDLE = 3'b001,
		TMR_RUN = 3'b010,
		TMR_DONE = 3'b100
	} eepc_tmr_state_t;

endpackage

// File: rtl/eepc_timer.sv
`timescale 1ns/1ps
`include "eepc_regs.svh"

module eepc_timer #(
	parameter int unsigned PROG_TICKS = `EEPC_PROG_TICKS
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic run,
	input wire logic [9:0] divisor,
	output logic done
);
	import eepc_pkg::*;

	eepc_tmr_state_t state_reg;
	logic [9:0] pre_reg;
	logic [15:0] tick_reg;
	logic done_reg;
	logic tick;

	// A tick is one full pass of the prescaler through the divider value.
	assign tick = (pre_reg >= divisor);
	assign done = done_reg;

	// -------------------------------------------------------------------------
	// Interval sequencer.
	// -------------------------------------------------------------------------
	// Dropping run at any time aborts, so a manual clear never leaves a stale count.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= TMR_IDLE;
			pre_reg <= 10'h000;
			tick_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= 1'b0;
			case (state_reg)
				TMR_IDLE: begin
					pre_reg <= 10'h000;
					tick_reg <= 16'h0000;
					if (run) begin
						state_reg <= TMR_RUN;
					end
				end
				TMR_RUN: begin
					if (!run) begin
						state_reg <= TMR_IDLE;
					end else if (tick) begin
						pre_reg <= 10'h000;
						if (tick_reg == 16'(PROG_TICKS - 1)) begin
							state_reg <= TMR_DONE;
							done_reg <= 1'b1;
						end else begin
							tick_reg <= tick_reg + 16'h0001;
						end
					end else begin
						pre_reg <= pre_reg + 10'h001;
					end
				end
				TMR_DONE: begin
					if (!run) begin
						state_reg <= TMR_IDLE;
					end
				end
				default: begin
					state_reg <= TMR_IDLE;
				end
			endcase
		end
	end

	property p_done_after_count;
		@(posedge core_clk) disable iff (reset)
		done_reg |-> $past(tick_reg) == 16'(PROG_TICKS - 1) && $past(run);
	endproperty
	a_done_after_count: assert property (p_done_after_count)
		else $error("Interval end without full tick count.");

endmodule

// File: rtl/eepc_ctrl.sv
`timescale 1ns/1ps
`include "eepc_regs.svh"

//Contract
// - Unless guarded, erase covers byte or word, row or whole array, set by two bits.
// - Erase-select picks program or erase; writable only while voltage is off.
// - Latch-arm low means normal reads; high captures the program target.
// - Latch-arm writes ignored while voltage applied or divider zero.
// - Mode bits and latch-arm may be written together or in any order.
// - Voltage-apply high drives array voltage; low removes it.
// - Voltage-apply sets only once latch-arm already set; joint write sets latch only.
// - While voltage applied, guard, auto, mode and latch bits are frozen.
// - With auto, hardware clears voltage-apply when the cycle completes.
// - While voltage applied, array writes do nothing; latches stay unchanged.
// - Next target may be written after voltage clears while latch stays armed.
// - Shadow word appears at its reserved location only while hide-shadow is zero.
// - After each reset, shadow word loads config and both divider registers.
// - Shadow high byte maps debug lock, hide-shadow, config 5:4, divider-high 1:0.
// - Divider must suit oscillator; latches refuse to arm while divider zero.
// - In normal mode divider registers accept only first write after reset.
// - With byte-select clear, row-select picks whole array or one 32-byte row.
// - Bulk-erase guard resets to one and blocks row and whole-array erase.
module eepc_ctrl #(
	parameter int unsigned PROG_TICKS = `EEPC_PROG_TICKS
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic special_mode_n,
	input wire logic [11:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] array_rdata,
	input wire logic [15:0] shadow_word,
	output logic hv_on,
	output logic latch_mode,
	output logic erase_mode,
	output eepc_pkg::eepc_scope_t erase_scope,
	output logic [11:0] latch_addr,
	output logic [7:0] latch_data,
	output logic latch_loaded,
	output logic shadow_visible
);
	import eepc_pkg::*;

	// -------------------------------------------------------------------------
	// Decode helpers.
	// -------------------------------------------------------------------------
	// The register window sits at the top of the map, above the shadow word.
	function automatic logic is_reg(input logic [11:0] a);
		is_reg = (a[11:4] == 8'(`EEPC_REG_BASE >> 4));
	endfunction

	function automatic logic is_shadow(input logic [11:0] a);
		is_shadow = (a == `EEPC_SHADOW_HI) || (a == `EEPC_SHADOW_LO);
	endfunction

	function automatic eepc_scope_t scope_of(input logic b, input logic r);
		scope_of = b ? SCOPE_BYTE : (r ? SCOPE_ROW : SCOPE_BULK);
	endfunction

	logic guard_reg, auto_reg, byte_reg, row_reg, erase_reg;
	logic latch_arm_reg, voltage_apply_reg;
	logic [7:0] mcr_reg;
	logic [1:0] divh_reg;
	logic [7:0] divl_reg;
	logic divh_lock_reg, divl_lock_reg;
	logic shadow_guard_reg;
	logic load_pending_reg;
	logic [7:0] rdata_reg;
	logic hv_reg;
	eepc_scope_t scope_reg;
	logic [11:0] laddr_reg;
	logic [7:0] ldata_reg;
	logic loaded_reg;
	logic visible_reg;
	logic timer_done;
	logic wr_ctrl, wr_mcr, wr_divh, wr_divl, wr_prot, wr_array;
	logic div_zero, guard_block, hw_clear;

	assign wr_ctrl = bus_wr && (bus_addr == `EEPC_ADDR_CTRL);
	assign wr_mcr = bus_wr && (bus_addr == `EEPC_ADDR_MCR);
	assign wr_divh = bus_wr && (bus_addr == `EEPC_ADDR_DIVH);
	assign wr_divl = bus_wr && (bus_addr == `EEPC_ADDR_DIVL);
	assign wr_prot = bus_wr && (bus_addr == `EEPC_ADDR_PROT);
	assign wr_array = bus_wr && !is_reg(bus_addr);
	assign div_zero = ({divh_reg, divl_reg} == 10'h000);
	assign hw_clear = auto_reg && voltage_apply_reg && timer_done;
	// Row and whole-array erase are the only scopes the guard blocks.
	assign guard_block = guard_reg && erase_reg && !byte_reg;

	assign bus_rdata = rdata_reg;
	assign hv_on = hv_reg;
	assign latch_mode = latch_arm_reg;
	assign erase_mode = erase_reg;
	assign erase_scope = scope_reg;
	assign latch_addr = laddr_reg;
	assign latch_data = ldata_reg;
	assign latch_loaded = loaded_reg;
	assign shadow_visible = visible_reg;

	// -------------------------------------------------------------------------
	// Control register.
	// -------------------------------------------------------------------------
	// Mode bits take any write while voltage is off, so one access or several
	// accesses in any order end in the same setup.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			guard_reg <= `EEPC_GUARD_RESET;
			auto_reg <= 1'b0;
			byte_reg <= 1'b0;
			row_reg <= 1'b0;
			erase_reg <= 1'b0;
		end else if (clk_en && wr_ctrl && !voltage_apply_reg) begin
			guard_reg <= bus_wdata[`EEPC_B_GUARD];
			auto_reg <= bus_wdata[`EEPC_B_AUTO];
			byte_reg <= bus_wdata[`EEPC_B_BYTE];
			row_reg <= bus_wdata[`EEPC_B_ROW];
			erase_reg <= bus_wdata[`EEPC_B_ERASE];
		end
	end

	// Latch arm ignores every write while the divider is zero, since the interval
	// could not be timed, and is frozen while voltage is applied.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			latch_arm_reg <= 1'b0;
		end else if (clk_en && wr_ctrl && !voltage_apply_reg) begin
			if (!div_zero) begin
				latch_arm_reg <= bus_wdata[`EEPC_B_LATCH];
			end
		end
	end

	// Voltage apply sets only on an already armed latch; the hardware clear at
	// the end of an automatic interval takes priority over any write.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			voltage_apply_reg <= 1'b0;
		end else if (clk_en) begin
			if (hw_clear) begin
				voltage_apply_reg <= 1'b0;
			end else if (wr_ctrl) begin
				voltage_apply_reg <= bus_wdata[`EEPC_B_VAPPLY] && latch_arm_reg
					&& bus_wdata[`EEPC_B_LATCH];
			end
		end
	end

	// -------------------------------------------------------------------------
	// Configuration, divider and protection registers.
	// -------------------------------------------------------------------------
	// The shadow copy is taken one enabled edge after reset releases, so the
	// reset branch itself holds constants only.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			load_pending_reg <= 1'b1;
			mcr_reg <= 8'h00;
		end else if (clk_en) begin
			if (load_pending_reg) begin
				load_pending_reg <= 1'b0;
				mcr_reg <= {shadow_word[15:12], `EEPC_MCR_LOW_RESET};
			end else if (wr_mcr && !special_mode_n) begin
				mcr_reg <= {bus_wdata[7:4], mcr_reg[3:0]};
			end
		end
	end

	// Once locked in normal mode, a runaway write cannot retune the interval.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			divh_reg <= 2'h0;
			divh_lock_reg <= 1'b0;
		end else if (clk_en) begin
			if (load_pending_reg) begin
				divh_reg <= shadow_word[9:8];
			end else if (wr_divh && (!divh_lock_reg || !special_mode_n)) begin
				divh_reg <= bus_wdata[1:0];
				divh_lock_reg <= special_mode_n;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			divl_reg <= 8'h00;
			divl_lock_reg <= 1'b0;
		end else if (clk_en) begin
			if (load_pending_reg) begin
				divl_reg <= shadow_word[7:0];
			end else if (wr_divl && (!divl_lock_reg || !special_mode_n)) begin
				divl_reg <= bus_wdata;
				divl_lock_reg <= special_mode_n;
			end
		end
	end

	// Shadow guard keeps the shadow word out of the latches while set.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shadow_guard_reg <= `EEPC_PROT_RESET;
		end else if (clk_en && wr_prot) begin
			shadow_guard_reg <= bus_wdata[`EEPC_B_SGUARD];
		end
	end

	// -------------------------------------------------------------------------
	// Address and data latches.
	// -------------------------------------------------------------------------
	// Only byte writes are latched; an aligned word arrives as two byte writes
	// and the later one wins, which the array macro pairs by address.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			laddr_reg <= 12'h000;
			ldata_reg <= 8'h00;
			loaded_reg <= 1'b0;
		end else if (clk_en) begin
			if (!latch_arm_reg) begin
				loaded_reg <= 1'b0;
			end else if (wr_array && !voltage_apply_reg
				&& !(is_shadow(bus_addr) && shadow_guard_reg)) begin
				laddr_reg <= bus_addr;
				ldata_reg <= bus_wdata;
				loaded_reg <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Array-side outputs.
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			hv_reg <= 1'b0;
			scope_reg <= SCOPE_BULK;
			visible_reg <= 1'b0;
		end else if (clk_en) begin
			hv_reg <= voltage_apply_reg && !hw_clear && !guard_block;
			scope_reg <= scope_of(byte_reg, row_reg);
			visible_reg <= !mcr_reg[`EEPC_B_HIDE];
		end
	end

	// -------------------------------------------------------------------------
	// Read port: data stand in the cycle after the strobe only.
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else if (clk_en) begin
			rdata_reg <= 8'h00;
			if (bus_rd) begin
				if (is_reg(bus_addr)) begin
					case (bus_addr)
						`EEPC_ADDR_CTRL: rdata_reg <= {guard_reg, 1'b0, auto_reg, byte_reg,
							row_reg, erase_reg, latch_arm_reg, voltage_apply_reg};
						`EEPC_ADDR_MCR: rdata_reg <= mcr_reg;
						`EEPC_ADDR_DIVH: rdata_reg <= {6'h00, divh_reg};
						`EEPC_ADDR_DIVL: rdata_reg <= divl_reg;
						`EEPC_ADDR_PROT: rdata_reg <= {shadow_guard_reg, 7'h00};
						default: rdata_reg <= 8'h00;
					endcase
				end else if (is_shadow(bus_addr) && !mcr_reg[`EEPC_B_HIDE]) begin
					rdata_reg <= bus_addr[0] ? shadow_word[7:0] : shadow_word[15:8];
				end else begin
					rdata_reg <= array_rdata;
				end
			end
		end
	end

	// -------------------------------------------------------------------------
	// Automatic interval timer.
	// -------------------------------------------------------------------------
	eepc_timer #(
		.PROG_TICKS(PROG_TICKS)
	) u_timer (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.run(auto_reg && voltage_apply_reg),
		.divisor({divh_reg, divl_reg}),
		.done(timer_done)
	);

	// -------------------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------------------
	property p_joint_set;
		@(posedge core_clk) disable iff (reset)
		clk_en && wr_ctrl && !latch_arm_reg && bus_wdata[`EEPC_B_VAPPLY] |=> !voltage_apply_reg;
	endproperty
	a_joint_set: assert property (p_joint_set)
		else $error("Voltage apply set without prior latch arm.");

	property p_latch_zero_div;
		@(posedge core_clk) disable iff (reset)
		clk_en && wr_ctrl && div_zero |=> $stable(latch_arm_reg);
	endproperty
	a_latch_zero_div: assert property (p_latch_zero_div)
		else $error("Latch armed with zero divider.");

	property p_frozen_bits;
		@(posedge core_clk) disable iff (reset)
		voltage_apply_reg |=> $stable({guard_reg, auto_reg, byte_reg, row_reg, erase_reg,
			latch_arm_reg});
	endproperty
	a_frozen_bits: assert property (p_frozen_bits)
		else $error("Mode bit changed while voltage applied.");

	property p_erase_write;
		@(posedge core_clk) disable iff (reset)
		clk_en && wr_ctrl && !voltage_apply_reg |=> erase_reg == $past(bus_wdata[`EEPC_B_ERASE]);
	endproperty
	a_erase_write: assert property (p_erase_write)
		else $error("Erase select did not take write.");

	property p_latch_hold;
		@(posedge core_clk) disable iff (reset)
		voltage_apply_reg |=> $stable(laddr_reg) && $stable(ldata_reg);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("Latched target changed during cycle.");

	property p_div_once;
		@(posedge core_clk) disable iff (reset)
		special_mode_n && divl_lock_reg && !load_pending_reg |=> $stable(divl_reg);
	endproperty
	a_div_once: assert property (p_div_once)
		else $error("Locked divider changed in normal mode.");

	property p_auto_clear;
		@(posedge core_clk) disable iff (reset)
		clk_en && auto_reg && voltage_apply_reg && timer_done |=> !voltage_apply_reg ##1 !hv_reg;
	endproperty
	a_auto_clear: assert property (p_auto_clear)
		else $error("Voltage apply not cleared after interval.");

	property p_guard_hv;
		@(posedge core_clk) disable iff (reset)
		hv_reg |-> $past(voltage_apply_reg) && !$past(guard_block);
	endproperty
	a_guard_hv: assert property (p_guard_hv)
		else $error("Voltage on without apply or against guard.");

	property p_shadow_read;
		@(posedge core_clk) disable iff (reset)
		clk_en && bus_rd && bus_addr == `EEPC_SHADOW_HI && !mcr_reg[`EEPC_B_HIDE]
			|=> bus_rdata == $past(shadow_word[15:8]);
	endproperty
	a_shadow_read: assert property (p_shadow_read)
		else $error("Shadow high byte not visible.");

	property p_shadow_load;
		@(posedge core_clk) disable iff (reset)
		clk_en && load_pending_reg |=> divl_reg == $past(shadow_word[7:0])
			&& mcr_reg[7:4] == $past(shadow_word[15:12]);
	endproperty
	a_shadow_load: assert property (p_shadow_load)
		else $error("Shadow word not loaded after reset.");

endmodule

// File: bench/tb_eepc_ctrl.sv
`timescale 1ns/1ps
`include "eepc_regs.svh"

module tb_eepc_ctrl;
	import eepc_pkg::*;

	// ------------------------------------------------------------------------
	// Settings and signals.
	// ------------------------------------------------------------------------
	// A short interval keeps the automatic cycle to under twenty clocks.
	localparam int unsigned TICKS = 4;
	// Shadow high byte keeps the test and unmapped bits at one, divider high 0.
	localparam logic [15:0] SHADOW = 16'hBC03;
	localparam int TIMEOUT = 3000;

	logic core_clk;
	logic reset;
	logic clk_en;
	logic special_mode_n;
	logic [11:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_rdata;
	logic [7:0] array_rdata;
	logic [15:0] shadow_word;
	logic hv_on;
	logic latch_mode;
	logic erase_mode;
	eepc_scope_t erase_scope;
	logic [11:0] latch_addr;
	logic [7:0] latch_data;
	logic latch_loaded;
	logic shadow_visible;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	int n;

	eepc_ctrl #(.PROG_TICKS(TICKS)) dut (
		.core_clk(core_clk),
		.reset(reset),
		.clk_en(clk_en),
		.special_mode_n(special_mode_n),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.array_rdata(array_rdata),
		.shadow_word(shadow_word),
		.hv_on(hv_on),
		.latch_mode(latch_mode),
		.erase_mode(erase_mode),
		.erase_scope(erase_scope),
		.latch_addr(latch_addr),
		.latch_data(latch_data),
		.latch_loaded(latch_loaded),
		.shadow_visible(shadow_visible)
	);

	// ------------------------------------------------------------------------
	// Clock and hang guard.
	// ------------------------------------------------------------------------
	// Free running 50 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// A stuck poll loop must not keep the run alive forever.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------------------
	// Bus tasks and comparison.
	// ------------------------------------------------------------------------
	// Values are widened to 12 bits so that one compare serves every output.
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Each access starts on a rising edge and ends mid-cycle, so strobes never
	// get two assignments in one time step when calls follow each other.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		@(negedge core_clk);
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		@(negedge core_clk);
		chk(bus_rdata, exp);
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	// Hold reset for five cycles, then leave room for the shadow load.
	task automatic do_reset();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		idle(2);
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------------
	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		special_mode_n = 1'b1;
		bus_addr = 12'h000;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		array_rdata = 8'h6E;
		shadow_word = SHADOW;
		// Reset is sampled high at five edges; outputs are checked while it holds.
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk(erase_scope, 3'b100);
		chk(hv_on, 1'b0);
		@(posedge core_clk);
		reset <= 1'b0;
		idle(2);
		// Reset values and the shadow copy.
		rd_chk(`EEPC_ADDR_CTRL, 8'h80);
		rd_chk(`EEPC_ADDR_MCR, 8'hB0);
		rd_chk(`EEPC_ADDR_DIVH, 8'h00);
		rd_chk(`EEPC_ADDR_DIVL, 8'h03);
		rd_chk(`EEPC_ADDR_PROT, 8'h80);
		rd_chk(12'hFF5, 8'h00);
		rd_chk(`EEPC_SHADOW_HI, 8'hBC);
		chk(shadow_visible, 1'b1);
		// A low clock enable must swallow a control write completely.
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(`EEPC_ADDR_CTRL, 8'h24);
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd_chk(`EEPC_ADDR_CTRL, 8'h80);
		chk(erase_mode, 1'b0);
		// Divider write-once, then a zero divider refuses arming.
		wr(`EEPC_ADDR_DIVL, 8'h00);
		wr(`EEPC_ADDR_DIVL, 8'h03);
		rd_chk(`EEPC_ADDR_DIVL, 8'h00);
		wr(`EEPC_ADDR_DIVH, 8'h00);
		wr(`EEPC_ADDR_CTRL, 8'h82);
		rd_chk(`EEPC_ADDR_CTRL, 8'h80);
		chk(latch_mode, 1'b0);
		// A second reset restores the divider from the shadow word.
		do_reset();
		rd_chk(`EEPC_ADDR_DIVL, 8'h03);
		// Manual program cycle.
		wr(`EEPC_ADDR_CTRL, 8'h83);
		rd_chk(`EEPC_ADDR_CTRL, 8'h82);
		chk(latch_mode, 1'b1);
		wr(12'h123, 8'h5A);
		chk(latch_addr, 12'h123);
		chk(latch_data, 8'h5A);
		chk(latch_loaded, 1'b1);
		wr(`EEPC_ADDR_CTRL, 8'h83);
		idle(1);
		chk(hv_on, 1'b1);
		chk(erase_mode, 1'b0);
		wr(12'h124, 8'hA5);
		chk(latch_addr, 12'h123);
		chk(latch_data, 8'h5A);
		wr(`EEPC_ADDR_CTRL, 8'h07);
		rd_chk(`EEPC_ADDR_CTRL, 8'h83);
		wr(`EEPC_ADDR_CTRL, 8'h82);
		idle(1);
		chk(hv_on, 1'b0);
		wr(12'h125, 8'h11);
		chk(latch_addr, 12'h125);
		chk(latch_data, 8'h11);
		wr(`EEPC_ADDR_CTRL, 8'h80);
		idle(1);
		chk(latch_mode, 1'b0);
		chk(latch_loaded, 1'b0);
		// Every erase granularity, selected by the byte and row bits.
		for (int i = 0; i < 4; i++) begin
			wr(`EEPC_ADDR_CTRL, {3'b100, i[1], i[0], 3'b100});
			idle(1);
			chk(erase_scope, i[1] ? 3'b001 : (i[0] ? 3'b010 : 3'b100));
			chk(erase_mode, 1'b1);
		end
		// The guard blocks row erase; clearing it lets the voltage through.
		wr(`EEPC_ADDR_CTRL, 8'h8E);
		wr(12'h040, 8'hFF);
		wr(`EEPC_ADDR_CTRL, 8'h8F);
		idle(1);
		chk(hv_on, 1'b0);
		wr(`EEPC_ADDR_CTRL, 8'h8E);
		wr(`EEPC_ADDR_CTRL, 8'h0E);
		wr(`EEPC_ADDR_CTRL, 8'h0F);
		idle(1);
		chk(hv_on, 1'b1);
		wr(`EEPC_ADDR_CTRL, 8'h0E);
		wr(`EEPC_ADDR_CTRL, 8'h80);
		// Automatic shutdown: (divider + 1) * TICKS = 16 cycles after apply.
		wr(`EEPC_ADDR_CTRL, 8'hA2);
		wr(12'h200, 8'h3C);
		wr(`EEPC_ADDR_CTRL, 8'hA3);
		rd_chk(`EEPC_ADDR_CTRL, 8'hA3);
		n = 0;
		while (hv_on === 1'b1 && n < 40) begin
			@(negedge core_clk);
			n++;
		end
		chk(n >= 8 && n <= 18, 1'b1);
		rd_chk(`EEPC_ADDR_CTRL, 8'hA2);
		wr(`EEPC_ADDR_CTRL, 8'h80);
		// Special mode: hiding the shadow word hands the location to the array.
		@(posedge core_clk);
		special_mode_n <= 1'b0;
		// Shadow preset: divider, drop guard, show shadow, program, guard again.
		wr(`EEPC_ADDR_DIVL, 8'h07);
		wr(`EEPC_ADDR_DIVL, 8'h05);
		rd_chk(`EEPC_ADDR_DIVL, 8'h05);
		wr(`EEPC_ADDR_PROT, 8'h00);
		wr(`EEPC_ADDR_MCR, 8'h30);
		rd_chk(`EEPC_ADDR_MCR, 8'h30);
		wr(`EEPC_ADDR_CTRL, 8'h02);
		wr(`EEPC_SHADOW_LO, 8'h05);
		chk(latch_addr, `EEPC_SHADOW_LO);
		chk(latch_data, 8'h05);
		// Only divider bits 1:0 of the high byte are programmed; the rest stay one.
		wr(`EEPC_SHADOW_HI, 8'hFC);
		chk(latch_addr, `EEPC_SHADOW_HI);
		chk(latch_data, 8'hFC);
		wr(`EEPC_ADDR_PROT, 8'h80);
		wr(`EEPC_SHADOW_LO, 8'h11);
		chk(latch_addr, `EEPC_SHADOW_HI);
		chk(latch_data, 8'hFC);
		wr(`EEPC_ADDR_CTRL, 8'h00);
		wr(`EEPC_ADDR_MCR, 8'h40);
		idle(1);
		chk(shadow_visible, 1'b0);
		rd_chk(`EEPC_SHADOW_HI, 8'h6E);
		give_verdict();
	end

endmodule
